// ---- logic/cpu_programming_model_regs.sv ----
// Architectural register state of the core: general registers, pointer,
// status word, multiply-accumulate registers and control registers.
// Assumes the pipeline drives one request of each kind per cycle.
//
// Summary of operation
// - Status supervisor bit selects user or supervisor registers and instructions.
// - User mode reaches user and multiply-accumulate state only.
// - Sixteen 32-bit registers, eight data, eight address, last is stack.
// - Data registers take bit, byte, word, long writes and serve as index.
// - Address registers zero to six take word and long writes only.
// - One shared stack register serves calls, returns and exceptions.
// - Stack register loads from the reset vector fetched at address zero.
// - Call pushes program counter; return reloads it from the stack.
// - Exception pushes counter and status; return-from-exception restores the counter, and the status only in supervisor mode.
// - Counter steps sequentially, loads targets, bases relative addressing.
// - Flag byte is status bits 7..0; bits six and five stay clear.
// - Flag bit seven selects forward branch prediction taken or not.
// - Extend flag takes carry on arithmetic, else held or given value.
// - Negative flag follows result most significant bit.
// - Zero flag set when result is zero.
// - Overflow flag set when result does not fit operand size.
// - Carry flag set on add carry-out or subtract borrow.
// - Sixteen-bit mask register gates multiply-accumulate operand addresses.
// - Eight-bit multiply-accumulate status holds configuration and result flags.
// - Control registers chosen by a twelve-bit code in the move instruction.
// - Codes 002, 004, 005 pick cache and two region registers.
// - Codes 801, C04, C0F pick vector, RAM and peripheral bases.
// - Status bit thirteen: zero user, one supervisor.
`timescale 1ns/100ps
`default_nettype none

module cpu_programming_model_regs (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Reset vector load
    input  wire logic        rst_vec_valid,
    input  wire logic [31:0] rst_vec_sp,
    // General register read ports
    input  wire logic [3:0]  rd_a_sel,
    input  wire logic [3:0]  rd_b_sel,
    output logic      [31:0] rd_a_data,
    output logic      [31:0] rd_b_data,
    // General register write port
    input  wire logic        gp_we,
    input  wire logic [3:0]  gp_sel,
    input  wire logic [1:0]  gp_size,
    input  wire logic        gp_bit_op,
    input  wire logic [4:0]  gp_bit_num,
    input  wire logic [31:0] gp_wdata,
    // Stack pointer adjust
    input  wire logic        sp_we,
    input  wire logic [31:0] sp_wdata,
    // Program counter
    input  wire logic [4:0]  pc_op,
    input  wire logic [31:0] pc_target,
    input  wire logic [31:0] stack_pc,
    input  wire logic [15:0] stack_sr,
    output logic      [31:0] instruction_pointer,
    // Exception entry
    input  wire logic        exc_enter,
    input  wire logic        exc_super,
    output logic      [31:0] push_pc,
    output logic      [15:0] push_sr,
    // Flags from the execute stage
    input  wire logic        flag_we,
    input  wire logic        flag_arith,
    input  wire logic        flag_x_we,
    input  wire logic        flag_x_val,
    input  wire logic [31:0] flag_result,
    input  wire logic [1:0]  flag_size,
    input  wire logic        flag_ovf,
    input  wire logic        flag_carry,
    // Status word and flag byte writes
    input  wire logic        sr_we,
    input  wire logic        cc_we,
    input  wire logic [15:0] sr_wdata,
    output logic      [15:0] processor_status_word,
    output logic             supervisor_mode,
    output logic             predict_fwd_taken,
    // Multiply-accumulate registers
    input  wire logic        mask_we,
    input  wire logic [15:0] mask_wdata,
    input  wire logic        mult_accum_status_we,
    input  wire logic [7:0]  mult_accum_status_wdata,
    output logic      [15:0] operand_mask,
    output logic      [7:0]  mult_accum_status,
    // Control register move
    input  wire logic        ctrl_we,
    input  wire logic        ctrl_re,
    input  wire logic [11:0] ctrl_reg_code,
    input  wire logic [31:0] ctrl_wdata,
    output logic      [31:0] ctrl_rdata,
    output logic             ctrl_bad_code,
    // Privilege
    input  wire logic        priv_instr,
    output logic             priv_violation
);

    logic [31:0] gp_q [16];
    logic [31:0] pc_q;
    logic [15:0] sr_q;
    logic [15:0] mask_q;
    logic [7:0]  mult_accum_status_q;
    logic [31:0] cache_control_q;
    logic [31:0] region_attr_0_q;
    logic [31:0] region_attr_1_q;
    logic [31:0] exception_table_base_q;
    logic [31:0] onchip_ram_base_q;
    logic [31:0] peripheral_space_base_q;
    logic [31:0] rd_a_q;
    logic [31:0] rd_b_q;
    logic [31:0] ctrl_rdata_q;
    logic        bad_q;
    logic        viol_q;
    logic [31:0] push_pc_q;
    logic [15:0] push_sr_q;

    // Privilege checks
    wire         super_w   = sr_q[cpu_regs_pkg::SR_SUPER];
    wire         priv_req  = priv_instr | ctrl_we | ctrl_re | sr_we;
    wire         blocked   = priv_req & ~super_w;

    // Control code decode
    wire         hit_cache = (ctrl_reg_code == cpu_regs_pkg::CRC_CACHE);
    wire         hit_reg0  = (ctrl_reg_code == cpu_regs_pkg::CRC_REGION0);
    wire         hit_reg1  = (ctrl_reg_code == cpu_regs_pkg::CRC_REGION1);
    wire         hit_excb  = (ctrl_reg_code == cpu_regs_pkg::CRC_EXCBASE);
    wire         hit_ram   = (ctrl_reg_code == cpu_regs_pkg::CRC_RAMBASE);
    wire         hit_per   = (ctrl_reg_code == cpu_regs_pkg::CRC_PERBASE);
    wire         hit_any   = hit_cache | hit_reg0 | hit_reg1 | hit_excb | hit_ram | hit_per;
    wire         ctrl_wr   = ctrl_we & super_w & hit_any;
    wire [31:0]  ctrl_mux  = hit_cache ? cache_control_q :
                             hit_reg0  ? region_attr_0_q :
                             hit_reg1  ? region_attr_1_q :
                             hit_excb  ? exception_table_base_q :
                             hit_ram   ? onchip_ram_base_q :
                             hit_per   ? peripheral_space_base_q : 32'h0000_0000;

    // Sized general register write data
    wire         is_addr   = gp_sel[3];
    wire [31:0]  gp_old    = gp_q[gp_sel];
    wire [31:0]  bit_mask  = 32'h0000_0001 << gp_bit_num;
    wire [31:0]  wr_byte   = {gp_old[31:8], gp_wdata[7:0]};
    wire [31:0]  wr_word   = is_addr ? {{16{gp_wdata[15]}}, gp_wdata[15:0]}
                                     : {gp_old[31:16], gp_wdata[15:0]};
    wire [31:0]  wr_bit    = (gp_old & ~bit_mask) | ({32{gp_wdata[0]}} & bit_mask);
    wire [31:0]  gp_data   = gp_bit_op               ? wr_bit  :
                             gp_size == cpu_regs_pkg::SZ_BYTE ? wr_byte :
                             gp_size == cpu_regs_pkg::SZ_WORD ? wr_word : gp_wdata;
    // Address registers refuse byte and bit writes
    wire         gp_ok     = gp_we & ~(is_addr & (gp_bit_op |
                             gp_size == cpu_regs_pkg::SZ_BYTE));

    // Flag computation
    wire         msb_w     = flag_size == cpu_regs_pkg::SZ_BYTE ? flag_result[7] :
                             flag_size == cpu_regs_pkg::SZ_WORD ? flag_result[15] :
                             flag_result[31];
    wire         zero_w    = flag_size == cpu_regs_pkg::SZ_BYTE ? ~|flag_result[7:0] :
                             flag_size == cpu_regs_pkg::SZ_WORD ? ~|flag_result[15:0] :
                             ~|flag_result;
    wire         x_new     = flag_arith ? flag_carry :
                             flag_x_we  ? flag_x_val : sr_q[cpu_regs_pkg::CC_EXT];
    wire [7:0]   cc_calc   = {sr_q[cpu_regs_pkg::CC_PRED], 2'b00, x_new, msb_w, zero_w,
                              flag_ovf, flag_carry};
    // Full word only on a supervisor status write; flag-byte writes keep the system byte
    wire [15:0]  sr_sw     = (sr_we & super_w) ? (sr_wdata & cpu_regs_pkg::SR_WMASK)
                                     : {sr_q[15:8], sr_wdata[7:0] & cpu_regs_pkg::CC_WMASK};
    wire [15:0]  sr_exc    = {sr_q[15:14], exc_super, sr_q[12:0]};

    // General registers; index fifteen is the shared stack pointer
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_gp
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    gp_q[gi] <= 32'h0000_0000;
                end else if (gi == 15 && rst_vec_valid) begin
                    gp_q[gi] <= rst_vec_sp;
                end else if (gi == 15 && sp_we) begin
                    gp_q[gi] <= sp_wdata;
                end else if (gp_ok && gp_sel == gi) begin
                    gp_q[gi] <= gp_data;
                end
            end
        end
    endgenerate

    // Program counter
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pc_q <= cpu_regs_pkg::RESET_VEC;
        end else begin
            unique case (pc_op)
                cpu_regs_pkg::PC_SEQ:  pc_q <= pc_q + cpu_regs_pkg::PC_STEP;
                cpu_regs_pkg::PC_JUMP: pc_q <= pc_target;
                cpu_regs_pkg::PC_RET:  pc_q <= stack_pc;
                cpu_regs_pkg::PC_RTE:  pc_q <= stack_pc;
                default:               pc_q <= pc_q;
            endcase
        end
    end

    // Status word
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sr_q <= cpu_regs_pkg::SR_RESET;
        end else if (exc_enter) begin
            sr_q <= sr_exc;
        end else if (pc_op == cpu_regs_pkg::PC_RTE && super_w) begin
            sr_q <= stack_sr & cpu_regs_pkg::SR_WMASK;
        end else if ((sr_we && super_w) || cc_we) begin
            sr_q <= sr_sw;
        end else if (flag_we) begin
            sr_q <= {sr_q[15:8], cc_calc};
        end
    end

    // Exception and call push values
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            push_pc_q <= 32'h0000_0000;
            push_sr_q <= cpu_regs_pkg::SR_RESET;
        end else begin
            push_pc_q <= pc_q;
            push_sr_q <= sr_q;
        end
    end

    // Multiply-accumulate registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mask_q  <= 16'hFFFF;
            mult_accum_status_q <= 8'h00;
        end else begin
            if (mask_we) mask_q <= mask_wdata;
            if (mult_accum_status_we) mult_accum_status_q <= mult_accum_status_wdata;
        end
    end

    // Control registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cache_control_q         <= cpu_regs_pkg::CTRL_RESET;
            region_attr_0_q         <= cpu_regs_pkg::CTRL_RESET;
            region_attr_1_q         <= cpu_regs_pkg::CTRL_RESET;
            exception_table_base_q  <= cpu_regs_pkg::CTRL_RESET;
            onchip_ram_base_q       <= cpu_regs_pkg::CTRL_RESET;
            peripheral_space_base_q <= cpu_regs_pkg::CTRL_RESET;
        end else if (ctrl_wr) begin
            if (hit_cache) cache_control_q <= ctrl_wdata;
            if (hit_reg0) region_attr_0_q <= ctrl_wdata;
            if (hit_reg1) region_attr_1_q <= ctrl_wdata;
            if (hit_excb) exception_table_base_q <= ctrl_wdata & cpu_regs_pkg::EXCB_MASK;
            if (hit_ram) onchip_ram_base_q <= ctrl_wdata;
            if (hit_per) peripheral_space_base_q <= ctrl_wdata;
        end
    end

    // Registered read ports and status
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_a_q       <= 32'h0000_0000;
            rd_b_q       <= 32'h0000_0000;
            ctrl_rdata_q <= 32'h0000_0000;
            bad_q        <= 1'b0;
            viol_q       <= 1'b0;
        end else begin
            rd_a_q       <= gp_q[rd_a_sel];
            rd_b_q       <= gp_q[rd_b_sel];
            ctrl_rdata_q <= (ctrl_re && super_w) ? ctrl_mux : 32'h0000_0000;
            bad_q        <= (ctrl_we | ctrl_re) & super_w & ~hit_any;
            viol_q       <= blocked;
        end
    end

    assign rd_a_data             = rd_a_q;
    assign rd_b_data             = rd_b_q;
    assign instruction_pointer   = pc_q;
    assign push_pc               = push_pc_q;
    assign push_sr               = push_sr_q;
    assign processor_status_word = sr_q;
    assign supervisor_mode       = sr_q[cpu_regs_pkg::SR_SUPER];
    assign predict_fwd_taken     = sr_q[cpu_regs_pkg::CC_PRED];
    assign operand_mask          = mask_q;
    assign mult_accum_status     = mult_accum_status_q;
    assign ctrl_rdata            = ctrl_rdata_q;
    assign ctrl_bad_code         = bad_q;
    assign priv_violation        = viol_q;

    // Checks
    a_user_ctrl_blocked: assert property (@(posedge clk) disable iff (sys_rst)
        (ctrl_we && !super_w) |=> $stable(cache_control_q) && $stable(exception_table_base_q))
        else $error("user control write changed state");
    a_viol_raised: assert property (@(posedge clk) disable iff (sys_rst)
        (priv_instr && !super_w) |=> priv_violation)
        else $error("violation not raised");
    a_reserved_clear: assert property (@(posedge clk) disable iff (sys_rst)
        sr_q[6:5] == 2'b00)
        else $error("reserved flag bits set");
    a_zero_flag: assert property (@(posedge clk) disable iff (sys_rst)
        (flag_we && !exc_enter && !sr_we && !cc_we && pc_op != cpu_regs_pkg::PC_RTE
         && flag_result == 32'h0 && flag_size == cpu_regs_pkg::SZ_LONG)
        |=> sr_q[cpu_regs_pkg::CC_ZERO] && !sr_q[cpu_regs_pkg::CC_NEG])
        else $error("zero flag wrong");
    a_pc_seq_step: assert property (@(posedge clk) disable iff (sys_rst)
        (pc_op == cpu_regs_pkg::PC_SEQ) |=> pc_q == $past(pc_q) + 32'h2)
        else $error("counter did not step");
    a_sp_reset_vec: assert property (@(posedge clk) disable iff (sys_rst)
        rst_vec_valid |=> gp_q[15] == $past(rst_vec_sp))
        else $error("stack not loaded from vector");
    a_addr_no_byte: assert property (@(posedge clk) disable iff (sys_rst)
        (gp_we && gp_sel == 4'h3 + 4'h8 && gp_size == cpu_regs_pkg::SZ_BYTE)
        |=> $stable(gp_q[11]))
        else $error("address byte write took effect");
    a_excb_write: assert property (@(posedge clk) disable iff (sys_rst)
        (ctrl_we && super_w && ctrl_reg_code == 12'h801)
        |=> exception_table_base_q == ($past(ctrl_wdata) & 32'hFFF0_0000))
        else $error("vector base not written");
    a_carry_to_x: assert property (@(posedge clk) disable iff (sys_rst)
        (flag_we && flag_arith && !exc_enter && !sr_we && !cc_we
         && pc_op != cpu_regs_pkg::PC_RTE)
        |=> sr_q[cpu_regs_pkg::CC_EXT] == sr_q[cpu_regs_pkg::CC_CARRY])
        else $error("extend differs from carry");

endmodule : cpu_programming_model_regs

`default_nettype wire

// ---- logic/cpu_regs_pkg.sv ----
// Constants for the programming-model register file.
// Assumes a single core clock and a pipeline that drives the update ports.
`default_nettype none

package cpu_regs_pkg;

    // Control register codes
    localparam logic [11:0] CRC_CACHE   = 12'h002;
    localparam logic [11:0] CRC_REGION0 = 12'h004;
    localparam logic [11:0] CRC_REGION1 = 12'h005;
    localparam logic [11:0] CRC_EXCBASE = 12'h801;
    localparam logic [11:0] CRC_RAMBASE = 12'hC04;
    localparam logic [11:0] CRC_PERBASE = 12'hC0F;

    // Status word field positions
    localparam int SR_SUPER  = 13;
    localparam int CC_PRED   = 7;
    localparam int CC_EXT    = 4;
    localparam int CC_NEG    = 3;
    localparam int CC_ZERO   = 2;
    localparam int CC_OVF    = 1;
    localparam int CC_CARRY  = 0;

    // Reset values, write masks and counter step
    localparam logic [15:0] SR_RESET    = 16'h2700;
    localparam logic [15:0] SR_WMASK    = 16'hB79F;
    localparam logic [7:0]  CC_WMASK    = 8'h9F;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    localparam logic [31:0] EXCB_MASK   = 32'hFFF0_0000;
    localparam logic [31:0] RESET_VEC   = 32'h0000_0000;
    localparam logic [31:0] PC_STEP     = 32'h0000_0002;

    // Operand sizes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;

    // Program counter update kinds
    typedef enum logic [4:0] {
        PC_HOLD = 5'b00001,
        PC_SEQ  = 5'b00010,
        PC_JUMP = 5'b00100,
        PC_RET  = 5'b01000,
        PC_RTE  = 5'b10000
    } pc_op_e;

endpackage : cpu_regs_pkg

`default_nettype wire

// ---- verification/pipe_model.sv ----
// Pipeline-side model: reset vector fetch and a one-entry stack memory.
// Assumes the bench says when the stacked counter and status are saved.
`timescale 1ns/100ps
`default_nettype none

module pipe_model #(
    parameter logic [31:0] VEC_SP = 32'h0000_4000
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Save request and values offered for stacking
    input  wire logic        save,
    input  wire logic [31:0] push_pc,
    input  wire logic [15:0] push_sr,
    // Reset vector and stack contents
    output logic             rst_vec_valid,
    output logic      [31:0] rst_vec_sp,
    output logic      [31:0] stack_pc,
    output logic      [15:0] stack_sr
);
    logic fetched_q;

    // Vector word only while valid, its inverse otherwise
    assign rst_vec_sp = rst_vec_valid ? VEC_SP : ~VEC_SP;

    // One vector fetch per reset, then stack writes on request
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fetched_q     <= 1'b0;
            rst_vec_valid <= 1'b0;
            stack_pc      <= 32'hA5A5_A5A5;
            stack_sr      <= 16'h5A5A;
        end else begin
            rst_vec_valid <= !fetched_q;
            fetched_q     <= 1'b1;
            if (save) begin
                stack_pc <= push_pc;
                stack_sr <= push_sr;
            end
        end
    end
endmodule : pipe_model

`default_nettype wire

// ---- verification/cpu_programming_model_regs_tb.sv ----
// Self-checking bench for the programming-model register file.
// Assumes the pipeline model supplies the reset vector and stack contents.
`timescale 1ns/100ps
`default_nettype none

module cpu_programming_model_regs_tb;
    localparam logic [31:0] VEC_SP = 32'h0000_4000;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        rst_vec_valid, save, gp_we, gp_bit_op, sp_we, exc_enter, exc_super;
    logic        flag_we, flag_arith, flag_x_we, flag_x_val, flag_ovf, flag_carry;
    logic        sr_we, cc_we, supervisor_mode, predict_fwd_taken, mask_we, mult_accum_status_we;
    logic        ctrl_we, ctrl_re, ctrl_bad_code, priv_instr, priv_violation;
    logic [31:0] rst_vec_sp, stack_pc, push_pc, instruction_pointer, pc_target;
    logic [31:0] rd_a_data, rd_b_data, gp_wdata, sp_wdata, flag_result, ctrl_wdata, ctrl_rdata;
    logic [15:0] stack_sr, push_sr, processor_status_word, sr_wdata, mask_wdata, operand_mask;
    logic [3:0]  rd_a_sel, rd_b_sel, gp_sel;
    logic [1:0]  gp_size, flag_size;
    logic [4:0]  gp_bit_num, pc_op;
    logic [7:0]  mult_accum_status_wdata, mult_accum_status;
    logic [11:0] ctrl_reg_code;
    int          err_count = 0;
    int          checks = 0;

    // Design and pipeline model
    cpu_programming_model_regs cpu_programming_model_regs_inst (.clk, .sys_rst,
        .rst_vec_valid, .rst_vec_sp, .rd_a_sel, .rd_b_sel, .rd_a_data, .rd_b_data, .gp_we,
        .gp_sel, .gp_size, .gp_bit_op, .gp_bit_num, .gp_wdata, .sp_we, .sp_wdata, .pc_op,
        .pc_target, .stack_pc, .stack_sr, .instruction_pointer, .exc_enter, .exc_super,
        .push_pc, .push_sr, .flag_we, .flag_arith, .flag_x_we, .flag_x_val, .flag_result,
        .flag_size, .flag_ovf, .flag_carry, .sr_we, .cc_we, .sr_wdata, .processor_status_word,
        .supervisor_mode, .predict_fwd_taken, .mask_we, .mask_wdata, .mult_accum_status_we, .mult_accum_status_wdata,
        .operand_mask, .mult_accum_status, .ctrl_we, .ctrl_re, .ctrl_reg_code, .ctrl_wdata,
        .ctrl_rdata, .ctrl_bad_code, .priv_instr, .priv_violation);
    pipe_model #(.VEC_SP(VEC_SP)) pipe_model_inst (.clk, .sys_rst, .save, .push_pc,
        .push_sr, .rst_vec_valid, .rst_vec_sp, .stack_pc, .stack_sr);

    // Core clock, 5 ns period
    always #2.5 clk = ~clk;

    task automatic tick;
        @(negedge clk);
    endtask : tick

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Drops every strobe; counter held
    task automatic idle;
        {gp_we, gp_bit_op, sp_we, exc_enter, exc_super, flag_we, flag_arith, save} = '0;
        {flag_x_we, flag_x_val, flag_ovf, flag_carry, sr_we, cc_we, mask_we, mult_accum_status_we} = '0;
        {ctrl_we, ctrl_re, priv_instr} = '0;
        pc_op = cpu_regs_pkg::PC_HOLD;
    endtask : idle

    // One request edge, then one quiet edge
    task automatic fire;
        tick();
        idle();
        tick();
    endtask : fire

    task automatic gpw(input logic [3:0] s, input logic [1:0] z, input logic [31:0] d);
        gp_we = 1'b1;
        gp_sel = s;
        gp_size = z;
        gp_wdata = d;
        fire();
    endtask : gpw

    task automatic rd(input logic [3:0] a, input logic [3:0] b, input logic [31:0] ea,
                      input logic [31:0] eb);
        rd_a_sel = a;
        rd_b_sel = b;
        fire();
        chk("read_a", ea, rd_a_data);
        chk("read_b", eb, rd_b_data);
    endtask : rd

    task automatic fl(input logic a, input logic xw, input logic [31:0] r,
                      input logic [1:0] z, input logic v, input logic c, input logic [4:0] e);
        flag_we = 1'b1;
        flag_arith = a;
        flag_x_we = xw;
        flag_result = r;
        flag_size = z;
        flag_ovf = v;
        flag_carry = c;
        fire();
        chk("flags", {27'h0, e}, {27'h0, processor_status_word[4:0]});
    endtask : fl

    task automatic t_reset;
        chk("status", 32'h0000_2700, {16'h0, processor_status_word});
        chk("mode", 32'h1, 32'(supervisor_mode));
        chk("pc", 32'h0, instruction_pointer);
        chk("mac_status", 32'h0, {24'h0, mult_accum_status});
    endtask : t_reset

    task automatic t_gp;
        gpw(4'h3, cpu_regs_pkg::SZ_LONG, 32'h1234_5678);
        gpw(4'h3, cpu_regs_pkg::SZ_BYTE, 32'hFFFF_FFAB);
        gpw(4'hA, cpu_regs_pkg::SZ_WORD, 32'h0000_8001);
        gpw(4'hB, cpu_regs_pkg::SZ_BYTE, 32'h0000_0055);
        rd(4'h3, 4'hA, 32'h1234_56AB, 32'hFFFF_8001);
        rd(4'hB, 4'hF, 32'h0000_0000, VEC_SP);
        gpw(4'h3, cpu_regs_pkg::SZ_WORD, 32'hFFFF_CDEF);
        gp_bit_op = 1'b1;
        gp_bit_num = 5'd31;
        gpw(4'h3, cpu_regs_pkg::SZ_LONG, 32'h0000_0001);
        sp_we = 1'b1;
        sp_wdata = 32'h0000_3FFC;
        fire();
        rd(4'h3, 4'hF, 32'h9234_CDEF, 32'h0000_3FFC);
    endtask : t_gp

    task automatic t_pc;
        pc_op = cpu_regs_pkg::PC_JUMP;
        pc_target = 32'h0000_1000;
        fire();
        chk("pc", 32'h0000_1000, instruction_pointer);
        pc_op = cpu_regs_pkg::PC_SEQ;
        fire();
        chk("pc", 32'h0000_1002, instruction_pointer);
        save = 1'b1;
        fire();
        pc_op = cpu_regs_pkg::PC_JUMP;
        pc_target = 32'h0000_2000;
        fire();
        pc_op = cpu_regs_pkg::PC_RET;
        fire();
        chk("pc", 32'h0000_1002, instruction_pointer);
    endtask : t_pc

    task automatic t_flags;
        fl(1'b1, 1'b0, 32'h0000_0000, cpu_regs_pkg::SZ_LONG, 1'b0, 1'b1, 5'h15);
        fl(1'b1, 1'b0, 32'h8000_0000, cpu_regs_pkg::SZ_LONG, 1'b1, 1'b0, 5'h0A);
        fl(1'b1, 1'b0, 32'hFFFF_0080, cpu_regs_pkg::SZ_BYTE, 1'b0, 1'b0, 5'h08);
        fl(1'b1, 1'b0, 32'h0001_0000, cpu_regs_pkg::SZ_WORD, 1'b0, 1'b1, 5'h15);
        fl(1'b0, 1'b0, 32'h0000_0001, cpu_regs_pkg::SZ_LONG, 1'b0, 1'b0, 5'h10);
        fl(1'b0, 1'b1, 32'h0000_0000, cpu_regs_pkg::SZ_LONG, 1'b0, 1'b0, 5'h04);
    endtask : t_flags

    task automatic t_cc_mac;
        sr_wdata = 16'hFFFF;
        cc_we = 1'b1;
        mask_we = 1'b1;
        mask_wdata = 16'hA5C3;
        mult_accum_status_we = 1'b1;
        mult_accum_status_wdata = 8'h5A;
        fire();
        chk("status", 32'h0000_279F, {16'h0, processor_status_word});
        chk("predict", 32'h1, 32'(predict_fwd_taken));
        chk("mask", 32'h0000_A5C3, {16'h0, operand_mask});
        chk("mac_status", 32'h0000_005A, {24'h0, mult_accum_status});
        sr_wdata = 16'h0000;
        cc_we = 1'b1;
        fire();
        chk("predict", 32'h0, 32'(predict_fwd_taken));
    endtask : t_cc_mac

    task automatic t_ctrl;
        logic [11:0] codes [6];
        logic [31:0] d;
        codes = '{12'h002, 12'h004, 12'h005, 12'h801, 12'hC04, 12'hC0F};
        for (int i = 0; i < 12; i++) begin
            d = 32'(32'h1111_1111 * ((i % 6) + 1));
            ctrl_we = (i < 6);
            ctrl_re = (i >= 6);
            ctrl_reg_code = codes[i % 6];
            ctrl_wdata = d;
            tick();
            idle();
            if (i >= 6) begin
                chk("ctrl_read", (i == 9) ? (d & 32'hFFF0_0000) : d, ctrl_rdata);
            end
            tick();
        end
        ctrl_re = 1'b1;
        ctrl_reg_code = 12'h003;
        tick();
        idle();
        chk("bad_code", 32'h1, 32'(ctrl_bad_code));
        tick();
    endtask : t_ctrl

    task automatic t_user;
        for (int i = 0; i < 2; i++) begin
            sr_we = 1'b1;
            sr_wdata = (i == 0) ? 16'h0700 : 16'h2700;
            fire();
            chk("status", 32'h0000_0700, {16'h0, processor_status_word});
        end
        chk("mode", 32'h0, 32'(supervisor_mode));
        ctrl_we = 1'b1;
        ctrl_reg_code = 12'h002;
        ctrl_wdata = 32'hDEAD_BEEF;
        fire();
        ctrl_re = 1'b1;
        tick();
        idle();
        chk("ctrl_read", 32'h0, ctrl_rdata);
        chk("violation", 32'h1, 32'(priv_violation));
        tick();
        priv_instr = 1'b1;
        tick();
        idle();
        chk("violation", 32'h1, 32'(priv_violation));
        tick();
        chk("violation", 32'h0, 32'(priv_violation));
        cc_we = 1'b1;
        sr_wdata = 16'h2711;
        fire();
        chk("status", 32'h0000_0711, {16'h0, processor_status_word});
        save = 1'b1;
        fire();
        exc_enter = 1'b1;
        exc_super = 1'b1;
        fire();
        chk("mode", 32'h1, 32'(supervisor_mode));
        ctrl_re = 1'b1;
        ctrl_reg_code = 12'h002;
        tick();
        idle();
        chk("ctrl_read", 32'h1111_1111, ctrl_rdata);
        tick();
        pc_op = cpu_regs_pkg::PC_RTE;
        fire();
        chk("status", 32'h0000_0711, {16'h0, processor_status_word});
        chk("pc", 32'h0000_1002, instruction_pointer);
    endtask : t_user

    task automatic final_report;
        if (err_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    // Watchdog well beyond the expected run
    initial begin
        #20000;
        err_count++;
        final_report();
    end

    // Reset, then the scenarios in turn
    initial begin
        idle();
        {rd_a_sel, rd_b_sel, gp_sel, gp_size, gp_bit_num, gp_wdata, sp_wdata, pc_target} = '0;
        {flag_result, flag_size, sr_wdata, mask_wdata, mult_accum_status_wdata, ctrl_reg_code} = '0;
        ctrl_wdata = '0;
        repeat (6) tick();
        sys_rst = 1'b0;
        repeat (4) tick();
        t_reset();
        t_gp();
        t_pc();
        t_flags();
        t_cc_mac();
        t_ctrl();
        t_user();
        final_report();
    end
endmodule : cpu_programming_model_regs_tb

`default_nettype wire
